// file: rtl/qrw_pkg.sv
package qrw_pkg;

  // Clock and self-timed program cycle
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PROG_TIME_NS  = 2000;
  localparam logic [15:0] PROG_CYCLES   =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Command codes
  localparam logic [7:0] CMD_QUAD_READ  = 8'heb;
  localparam logic [7:0] CMD_WORD_READ  = 8'he7;
  localparam logic [7:0] CMD_WRAP_SET   = 8'h77;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h02;
  localparam logic [7:0] CMD_WRITE_EN   = 8'h06;
  localparam logic [7:0] CMD_STAT_LO    = 8'h05;
  localparam logic [7:0] CMD_STAT_HI    = 8'h35;
  localparam logic [7:0] CMD_READ_PARAM = 8'hc0;

  // Serial clock counts per phase
  localparam logic [5:0] SPI_BYTE_CLKS   = 6'h08;
  localparam logic [5:0] QPI_BYTE_CLKS   = 6'h02;
  localparam logic [5:0] ADDR_CLKS       = 6'h06;
  localparam logic [5:0] SPI_ADDR_CLKS   = 6'h18;
  localparam logic [5:0] MODE_CLKS       = 6'h02;
  localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] WORD_DUMMY_CLKS = 6'h02;
  localparam logic [5:0] WRAP_SET_CLKS   = 6'h20;
  localparam logic [5:0] NO_END_CLKS     = 6'h3f;
  localparam logic [5:0] QPI_DUMMY [4]   = '{6'h04, 6'h06, 6'h08, 6'h08};

  // Field positions and values
  localparam int         CONT_BITS_LSB  = 4;
  localparam logic [1:0] CONT_MODE_KEEP = 2'b10;
  localparam int         WRAP_EN_POS    = 4;
  localparam int         WRAP_LEN_LSB   = 5;
  localparam int         PARAM_DUM_LSB  = 4;
  localparam int         PARAM_WRAP_LSB = 0;
  localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;
  localparam logic [3:0] SPI_OUT_OE     = 4'h2;

  // Reset values and FIFO depth
  localparam logic       WRAP_EN_RESET  = 1'b1;
  localparam logic [1:0] WRAP_LEN_RESET = 2'b00;
  localparam logic [1:0] PARAM_RESET    = 2'b00;
  localparam int         FIFO_DEPTH     = 32;

  typedef enum logic [3:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_RDATA, PH_STAT,
    PH_WRAP, PH_PARAM, PH_PPADDR, PH_PPDATA, PH_IGNORE
  } qrw_phase_t;

  typedef struct packed {
    logic        csN;
    logic        sclk;
    logic [3:0]  io;
  } qrw_pins_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } qrw_prog_t;

  localparam qrw_pins_t PINS_IDLE = '{csN: 1'b1, sclk: 1'b0, io: 4'h0};

endpackage

// file: rtl/qrw_flash_ctl.sv
// Notes on behaviour
// RULE1 - Quad read: address, mode, dummy, nibble data
// RULE2 - Any start address, increments per output byte
// RULE3 - Quad reads need quad enable set
// RULE4 - Mode bits 10 skip next command byte
// RULE5 - Host may reset continuous mode first
// RULE6 - Wrap within aligned section until deselect
// RULE7 - No wrap in four-wire command mode
// RULE8 - Four-wire dummy clocks 4/6/8/8 from parameter
// RULE9 - Four-wire mode byte counts as dummy
// RULE10 - Word read: even address, two dummies
// RULE11 - Wrap setup: command, 24 dummies, 8 bits
// RULE12 - Wrap bit low enables 8..64 byte sections
// RULE13 - Wrap setting persists until disabled again
// RULE14 - Wrap length kept; parameter command changes it
// RULE15 - Page program needs write enable latch
// RULE16 - Host sends command, address, data bytes
// RULE17 - Program overflow wraps to page start
// RULE18 - Last 256 bytes kept, others untouched
// RULE19 - Program only on byte-aligned deselect
// RULE20 - Deselect starts cycle, busy, clears latch
// RULE21 - Protected page program is ignored
// RULE22 - Write enable command sets latch
// RULE23 - Read data driven on falling clock
// RULE24 - Status readable during program cycle
// RULE25 - Reset disables wrap, clears continuous mode
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Program word FIFO with a registered output stage
module qrw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  idle
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;

  // DEPTH must be a power of two so the pointers wrap by themselves
  wire push = inValid && inReady;
  wire pop  = (count != '0) && (!outValid || outReady);
  assign inReady = count != DEPTH[AW:0];
  assign idle    = (count == '0) && !outValid;

  // Pointers, fill level and output stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr    <= rdPtr + 1'b1;
        outData  <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge mclk) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Serial flash command engine
module qrw_flash_ctl
  import qrw_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe,
  input  wire logic        quadEnable,
  input  wire logic        fourWireMode,
  input  wire logic [4:0]  blockProtect,
  output logic      [23:0] memRdAddr,
  input  wire logic [7:0]  memRdData,
  output qrw_prog_t        progWord,
  output logic             progValid,
  input  wire logic        progReady,
  output logic             writeInProgress,
  output logic             writeEnableLatch,
  output logic             wrapEnableBit,
  output logic      [1:0]  wrapLengthField,
  output logic             continuousMode,
  output logic      [1:0]  dummyCfg
);
  qrw_pins_t  sync1;
  qrw_pins_t  sync2;
  qrw_pins_t  sync3;
  qrw_phase_t phase;
  qrw_phase_t cmdPhase;
  qrw_phase_t endPhase;
  logic [5:0]  cnt;
  logic [31:0] shIn;
  logic        isWord;
  logic        contWord;
  logic        nib;
  logic [7:0]  stSh;
  logic [23:0] ppAddr;
  logic [7:0]  col;
  logic        gotByte;
  logic [255:0] pageMask;
  logic [7:0]  pageBuf [256];
  logic        walking;
  logic [7:0]  walkIdx;
  logic [15:0] progTimer;
  logic        fifoInReady;
  logic        fifoIdle;
  logic [23:0] addrPrev;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage three only feeds the edge detectors
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= PINS_IDLE;
      sync2 <= PINS_IDLE;
      sync3 <= PINS_IDLE;
    end else if (clkEn) begin
      sync1 <= {csN, sclk, ioIn};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edges of the link, seen on the system clock
  wire sclkRise = sync2.sclk & ~sync3.sclk;
  wire sclkFall = ~sync2.sclk & sync3.sclk;
  wire csFall   = ~sync2.csN & sync3.csN;
  wire csRise   = sync2.csN & ~sync3.csN;
  wire selected = ~sync2.csN;

  ////////////////////////////////////////////////////////////////////////////
  // Shift-in width and phase length
  wire quadPhase = (phase == PH_ADDR) || (phase == PH_MODE) || (phase == PH_DUMMY);
  // RULE1 four bits per clock
  wire [31:0] shNext = (fourWireMode || quadPhase) ? {shIn[27:0], sync2.io}
                                                   : {shIn[30:0], sync2.io[0]};
  wire [5:0]  cntNext  = cnt + 6'h01;
  wire [5:0]  byteClks = fourWireMode ? QPI_BYTE_CLKS : SPI_BYTE_CLKS;
  // RULE8 RULE9 RULE10 dummy length, mode clocks counted in four-wire mode
  wire [5:0]  readDummy = isWord ? WORD_DUMMY_CLKS
                        : fourWireMode ? QPI_DUMMY[dummyCfg] - MODE_CLKS
                        : QUAD_DUMMY_CLKS;
  wire [5:0]  target =
    (phase == PH_CMD)    ? byteClks :
    (phase == PH_ADDR)   ? ADDR_CLKS :
    (phase == PH_MODE)   ? MODE_CLKS :
    (phase == PH_DUMMY)  ? readDummy :
    (phase == PH_WRAP)   ? WRAP_SET_CLKS :
    (phase == PH_PPADDR) ? (fourWireMode ? ADDR_CLKS : SPI_ADDR_CLKS) :
    (phase == PH_PPDATA || phase == PH_PARAM) ? byteClks : NO_END_CLKS;
  wire phaseEnd = selected && sclkRise && (target != NO_END_CLKS) && (cntNext == target);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire [7:0] cmdByte  = shNext[7:0];
  wire [1:0] modeBits = shNext[CONT_BITS_LSB +: 2];
  wire cmdEnd    = phaseEnd && (phase == PH_CMD);
  wire isQuadRd  = (cmdByte == CMD_QUAD_READ) || (cmdByte == CMD_WORD_READ);
  // RULE3 quad reads gated by quad enable
  wire rdOk      = isQuadRd && quadEnable && !writeInProgress;
  // RULE11 wrap setup only in standard serial mode
  wire wrapCmdOk = (cmdByte == CMD_WRAP_SET) && !fourWireMode;
  wire paramOk   = (cmdByte == CMD_READ_PARAM) && fourWireMode;
  // RULE15 page program needs the latch
  wire ppOk      = (cmdByte == CMD_PAGE_PROG) && writeEnableLatch && !writeInProgress;
  // RULE24 status answered even while busy
  wire isStat    = (cmdByte == CMD_STAT_LO) || (cmdByte == CMD_STAT_HI);
  wire wrEnOk    = (cmdByte == CMD_WRITE_EN) && !writeInProgress;

  assign cmdPhase = rdOk ? PH_ADDR : isStat ? PH_STAT : wrapCmdOk ? PH_WRAP :
                    paramOk ? PH_PARAM : ppOk ? PH_PPADDR : PH_IGNORE;
  assign endPhase = (phase == PH_CMD)   ? cmdPhase :
                    (phase == PH_ADDR)  ? PH_MODE :
                    (phase == PH_MODE)  ? PH_DUMMY :
                    (phase == PH_DUMMY) ? PH_RDATA :
                    (phase == PH_PPADDR || phase == PH_PPDATA) ? PH_PPDATA : PH_IGNORE;

  // Status bytes: WRITE_IN_PROGRESS, WRITE_ENABLE_LATCH, five protect bits; high byte carries quad enable
  wire [7:0] statLo = {1'b0, blockProtect, writeEnableLatch, writeInProgress};
  wire [7:0] statHi = {6'h00, quadEnable, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Read address stepping
  // RULE7 wrap never applies in four-wire command mode
  wire        wrapOn   = !wrapEnableBit && !fourWireMode;
  // RULE12 section of 8, 16, 32 or 64 bytes
  wire [7:0]  wrapMask = (WRAP_MIN_BYTES << wrapLengthField) - 8'h01;
  wire [7:0]  lowInc   = memRdAddr[7:0] + 8'h01;
  // RULE6 wrap inside the aligned section
  wire [23:0] nextAddr = wrapOn
    ? {memRdAddr[23:8], (memRdAddr[7:0] & ~wrapMask) | (lowInc & wrapMask)}
    : memRdAddr + 24'h000001;

  ////////////////////////////////////////////////////////////////////////////
  // Page protection and commit
  wire [8:0] protBlocks = (blockProtect[2:0] == 3'h0) ? 9'h000
                        : 9'(9'h001 << (blockProtect[2:0] - 3'h1));
  wire [8:0] ppBlock    = {1'b0, ppAddr[23:16]};
  wire pageProt = blockProtect[4] ? (ppBlock < protBlocks) : (ppBlock >= 9'h100 - protBlocks);
  // RULE19 RULE21 only byte-aligned, unprotected, latched programs run
  wire commit = csRise && (phase == PH_PPDATA) && (cnt == 6'h00) && gotByte &&
                writeEnableLatch && !pageProt;

  // Walk the page buffer, pushing only bytes that were received
  wire walkPush = walking && pageMask[walkIdx];
  wire walkStep = walking && (!pageMask[walkIdx] || fifoInReady);
  wire progDone = !walking && fifoIdle && (progTimer == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer; a deselect always ends the transaction
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= PH_IDLE;
      cnt   <= 6'h00;
      shIn  <= 32'h00000000;
    end else if (clkEn) begin
      if (csRise) begin
        phase <= PH_IDLE;
      end else if (csFall) begin
        // RULE4 continuous mode skips the command byte
        phase <= continuousMode ? PH_ADDR : PH_CMD;
        cnt   <= 6'h00;
      end else if (selected && sclkRise) begin
        shIn <= shNext;
        cnt  <= phaseEnd ? 6'h00 : cntNext;
        if (phaseEnd) begin
          phase <= endPhase;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read and status output; pins change a few cycles after the falling edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      memRdAddr <= 24'h000000;
      isWord    <= 1'b0;
      nib       <= 1'b0;
      stSh      <= 8'h00;
      ioOut     <= 4'h0;
      ioOe      <= 4'h0;
    end else if (clkEn) begin
      if (!selected) begin
        ioOe <= 4'h0;
        nib  <= 1'b0;
      end
      if (csFall && continuousMode) begin
        isWord <= contWord;
      end
      if (cmdEnd) begin
        isWord <= cmdByte == CMD_WORD_READ;
        stSh   <= (cmdByte == CMD_STAT_HI) ? statHi : statLo;
      end
      // RULE2 any starting address accepted
      if (phaseEnd && phase == PH_ADDR) begin
        memRdAddr <= shNext[23:0];
      end
      // RULE23 data leaves on the falling edge, high nibble first
      if (selected && sclkFall && phase == PH_RDATA) begin
        ioOe  <= 4'hf;
        ioOut <= nib ? memRdData[3:0] : memRdData[7:4];
        nib   <= !nib;
        // RULE2 step once per byte sent
        if (nib) begin
          memRdAddr <= nextAddr;
        end
      end
      // RULE24 status byte repeats for polling
      if (selected && sclkFall && phase == PH_STAT) begin
        ioOe  <= fourWireMode ? 4'hf : SPI_OUT_OE;
        ioOut <= fourWireMode ? stSh[7:4] : {2'b00, stSh[7], 1'b0};
        stSh  <= fourWireMode ? {stSh[3:0], stSh[7:4]} : {stSh[6:0], stSh[7]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Persistent read configuration
  always_ff @(posedge mclk) begin
    if (rst) begin
      // RULE25 wrap off, continuous mode cleared
      wrapEnableBit   <= WRAP_EN_RESET;
      wrapLengthField <= WRAP_LEN_RESET;
      dummyCfg        <= PARAM_RESET;
      continuousMode  <= 1'b0;
      contWord        <= 1'b0;
    end else if (clkEn) begin
      // RULE4 mode bits decide the next transaction
      if (phaseEnd && phase == PH_MODE) begin
        continuousMode <= modeBits == CONT_MODE_KEEP;
        contWord       <= isWord;
      end
      // RULE11 RULE13 last eight bits hold the wrap setting
      if (phaseEnd && phase == PH_WRAP) begin
        wrapEnableBit   <= shNext[WRAP_EN_POS];
        wrapLengthField <= shNext[WRAP_LEN_LSB +: 2];
      end
      // RULE14 RULE8 parameter command sets dummies and wrap length
      if (phaseEnd && phase == PH_PARAM) begin
        dummyCfg        <= shNext[PARAM_DUM_LSB +: 2];
        wrapLengthField <= shNext[PARAM_WRAP_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program data capture into the page buffer
  always_ff @(posedge mclk) begin
    if (rst) begin
      ppAddr   <= 24'h000000;
      col      <= 8'h00;
      gotByte  <= 1'b0;
      pageMask <= '0;
    end else if (clkEn) begin
      if (phaseEnd && phase == PH_PPADDR) begin
        ppAddr   <= shNext[23:0];
        col      <= shNext[7:0];
        gotByte  <= 1'b0;
        pageMask <= '0;
      end else if (phaseEnd && phase == PH_PPDATA) begin
        // RULE17 RULE18 column wraps, later bytes overwrite
        pageMask[col] <= 1'b1;
        col           <= col + 8'h01;
        gotByte       <= 1'b1;
      end
    end
  end

  // Buffer contents, no reset needed since the mask qualifies them
  always_ff @(posedge mclk) begin
    if (clkEn && phaseEnd && phase == PH_PPDATA) begin
      pageBuf[col] <= shNext[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write enable latch and self-timed program cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      writeEnableLatch <= 1'b0;
      writeInProgress  <= 1'b0;
      walking          <= 1'b0;
      walkIdx          <= 8'h00;
      progTimer        <= 16'h0000;
    end else if (clkEn) begin
      // RULE22 latch set once the command is decoded
      if (cmdEnd && wrEnOk) begin
        writeEnableLatch <= 1'b1;
      end else if (commit) begin
        writeEnableLatch <= 1'b0;
      end
      // RULE20 busy from deselect until buffer drained and time elapsed
      if (commit) begin
        writeInProgress <= 1'b1;
        walking         <= 1'b1;
        walkIdx         <= 8'h00;
        progTimer       <= PROG_CYCLES - 16'h0001;
      end else begin
        if (walkStep) begin
          walkIdx <= walkIdx + 8'h01;
          if (walkIdx == 8'hff) begin
            walking <= 1'b0;
          end
        end
        if (progTimer != 16'h0000) begin
          progTimer <= progTimer - 16'h0001;
        end
        if (writeInProgress && progDone) begin
          writeInProgress <= 1'b0;
        end
      end
    end
  end

  // RULE18 only received bytes leave, untouched ones are skipped
  qrw_fifo #(
    .WIDTH ($bits(qrw_prog_t)),
    .DEPTH (FIFO_WORDS)
  ) progFifo (
    .mclk     (mclk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (walkPush),
    .inReady  (fifoInReady),
    .inData   ({ppAddr[23:8], walkIdx, pageBuf[walkIdx]}),
    .outValid (progValid),
    .outReady (progReady),
    .outData  (progWord),
    .idle     (fifoIdle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      addrPrev <= memRdAddr;
    end
  end

  default clocking cbk @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire byteOut = clkEn && selected && sclkFall && (phase == PH_RDATA) && nib;

  sequence sProgBusy;
    (writeInProgress && !writeEnableLatch) [*8];
  endsequence

  chk_qe_gate: assert property ( // RULE3
    clkEn && cmdEnd && isQuadRd && !quadEnable |=> phase == PH_IGNORE)
    else $error("quad read accepted without quad enable");
  chk_addr_step: assert property ( // RULE2
    byteOut && !wrapOn |=> memRdAddr == addrPrev + 24'h000001)
    else $error("read address did not advance by one");
  chk_wrap_stay: assert property ( // RULE6
    byteOut && wrapOn |=> memRdAddr[23:8] == addrPrev[23:8] &&
    ((memRdAddr[7:0] ^ addrPrev[7:0]) & ~wrapMask) == 8'h00)
    else $error("wrapped read left its section");
  chk_wrap_eight: assert property ( // RULE12
    byteOut && wrapOn && wrapLengthField == 2'b00 && memRdAddr[2:0] == 3'h7
    |=> memRdAddr[2:0] == 3'h0 && memRdAddr[23:3] == addrPrev[23:3])
    else $error("eight-byte wrap did not return to start");
  chk_cont_mode: assert property ( // RULE4
    clkEn && phaseEnd && phase == PH_MODE |=> continuousMode == ($past(modeBits) == 2'b10))
    else $error("continuous mode does not follow mode bits");
  chk_cont_entry: assert property ( // RULE4
    clkEn && csFall && continuousMode |=> phase == PH_ADDR)
    else $error("continuous read did not skip command");
  chk_pp_gate: assert property ( // RULE15
    clkEn && cmdEnd && cmdByte == CMD_PAGE_PROG && !writeEnableLatch |=> phase == PH_IGNORE)
    else $error("page program accepted without latch");
  chk_prog_start: assert property ( // RULE20
    clkEn && commit |=> sProgBusy)
    else $error("program cycle not busy or latch not cleared");
  chk_prot_drop: assert property ( // RULE21
    clkEn && csRise && phase == PH_PPDATA && pageProt |=> !writeInProgress)
    else $error("protected page program started");
  chk_pp_boundary: assert property ( // RULE19
    clkEn && csRise && phase == PH_PPDATA && cnt != 6'h00 |=> !writeInProgress)
    else $error("unaligned page program started");
endmodule

// file: verification/qrw_host.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host controller model: owns csN, sclk and its side of the data lines
module qrw_host (
  input  wire logic       mclk,
  input  wire logic [3:0] ioOut,
  output logic            csN,
  output logic            sclk,
  output logic      [3:0] hostIo
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostIo = 4'h0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // change on fall, sample late
  // Low 50 ns, high 30 ns; a released line toggles so stale data never looks valid
  task automatic clk1(input logic [3:0] nib, input logic rel, output logic [3:0] got);
    sclk <= 1'b0;
    hostIo <= rel ? ~hostIo : nib;
    wait_n(5);
    got = ioOut;
    sclk <= 1'b1;
    wait_n(3);
  endtask

  task automatic frame_on();
    csN <= 1'b0;
    wait_n(3);
  endtask

  task automatic frame_off();
    csN <= 1'b1;
    hostIo <= ~hostIo;
    wait_n(6);
  endtask

  // Serial byte on data_line_0, MSB first; reply bit taken from line 1
  task automatic spi_byte(input logic [7:0] b, output logic [7:0] rd);
    logic [3:0] g;
    for (int i = 7; i >= 0; i--) begin
      clk1({3'b000, b[i]}, 1'b0, g);
      rd[i] = g[1];
    end
  endtask

  // Byte as two nibbles, high nibble first
  task automatic quad_byte(input logic [7:0] b, input logic rel, output logic [7:0] rd);
    logic [3:0] g;
    clk1(b[7:4], rel, g);
    rd[7:4] = g;
    clk1(b[3:0], rel, g);
    rd[3:0] = g;
  endtask
endmodule

// file: verification/quad_read_wrap_page_program_bench.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module quad_read_wrap_page_program_bench
  import qrw_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, quadEnable = 1'b1, fourWireMode = 1'b0, progReady = 1'b0;
  logic [4:0] blockProtect = 5'h00;
  logic csN, sclk, progValid, writeInProgress, writeEnableLatch, wrapEnableBit, continuousMode;
  logic [3:0] hostIo, ioIn, ioOut, ioOe;
  logic [1:0] wrapLengthField, dummyCfg;
  logic [23:0] memRdAddr;
  logic [7:0] memRdData, r;
  logic [7:0] rdBuf [8];
  qrw_prog_t progWord;
  qrw_prog_t words [$];
  int cyc = 0, failures = 0, numChecks = 0;
  int oeHits = 0;

  always #5 mclk = ~mclk;
  // Wire level: the device wins where it drives
  assign ioIn = (ioOe & ioOut) | (~ioOe & hostIo);
  assign memRdData = memRdAddr[7:0] ^ 8'h3c;

  qrw_host host (.mclk(mclk), .ioOut(ioOut), .csN(csN), .sclk(sclk), .hostIo(hostIo));
  qrw_flash_ctl dut (.mclk(mclk), .rst(rst), .clkEn(1'b1), .csN(csN), .sclk(sclk),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable),
    .fourWireMode(fourWireMode), .blockProtect(blockProtect), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .progWord(progWord), .progValid(progValid), .progReady(progReady),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
    .wrapEnableBit(wrapEnableBit), .wrapLengthField(wrapLengthField),
    .continuousMode(continuousMode), .dummyCfg(dummyCfg));

  // Stalling array side, cycle limit, program word capture
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    progReady <= cyc[1];
    if (cyc == 40000) begin
      failures = failures + 1;
      close_out();
    end
  end
  always @(posedge mclk) begin
    if (progValid && progReady) words.push_back(progWord);
    if (ioOe !== 4'h0) oeHits <= oeHits + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks = numChecks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [23:0] a, input int i, input int s);
    logic [23:0] e;
    e = (s == 0) ? a + 24'(i) : (a & ~24'(s - 1)) | ((a + 24'(i)) & 24'(s - 1));
    return e[7:0] ^ 8'h3c;
  endfunction

  // Quad read frame; reply bytes compared against the array pattern
  task automatic qread(input logic cmdOn, input logic [7:0] cmd, input logic [23:0] a,
    input logic [7:0] mode, input int dum, input int n, input int s);
    logic [3:0] g;
    host.frame_on();
    // Command byte takes two clocks in four-wire mode
    if (cmdOn && fourWireMode) host.quad_byte(cmd, 1'b0, r);
    if (cmdOn && !fourWireMode) host.spi_byte(cmd, r);
    for (int i = 2; i >= 0; i--) host.quad_byte(a[8*i +: 8], 1'b0, r);
    host.quad_byte(mode, 1'b0, r);
    repeat (dum) host.clk1(4'h0, 1'b0, g);
    for (int i = 0; i < n; i++) host.quad_byte(8'h00, 1'b1, rdBuf[i]);
    host.frame_off();
    for (int i = 0; i < n; i++) chk(32'(rdBuf[i]), 32'(exp_rd(a, i, s)));
  endtask

  task automatic cmd_frame(input logic [7:0] c, input logic [31:0] tail, input int nb,
    input int bits);
    logic [3:0] g;
    host.frame_on();
    host.spi_byte(c, r);
    for (int i = nb - 1; i >= 0; i--) host.spi_byte(tail[8*i +: 8], r);
    repeat (bits) host.clk1(4'h0, 1'b0, g);
    host.frame_off();
  endtask

  task automatic t_read();
    int base;
    chk(32'({wrapEnableBit, continuousMode, writeInProgress}), 32'h4);
    qread(1'b1, CMD_QUAD_READ, 24'h0012fe, 8'h20, 4, 3, 0);
    chk(32'(continuousMode), 32'h1);
    qread(1'b0, 8'h00, 24'h000040, 8'hff, 4, 2, 0);
    chk(32'(continuousMode), 32'h0);
    quadEnable = 1'b0;
    base = oeHits;
    // Extra dummies stand in the frame where data would come
    qread(1'b1, CMD_QUAD_READ, 24'h000010, 8'h00, 8, 0, 0);
    chk(32'(oeHits - base), 32'h0);
    quadEnable = 1'b1;
  endtask

  task automatic t_wrap();
    int s;
    for (int l = 0; l < 4; l++) begin
      s = 8 << l;
      cmd_frame(CMD_WRAP_SET, {8'h00, 16'h0000, 1'b0, 2'(l), 5'h00}, 4, 0);
      chk(32'({wrapEnableBit, wrapLengthField}), 32'(l));
      qread(1'b1, CMD_QUAD_READ, 24'h000100 | 24'(s - 2), 8'h00, 4, 4, s);
    end
    qread(1'b1, CMD_WORD_READ, 24'h00007c, 8'h00, 2, 6, 64);
    fourWireMode = 1'b1;
    host.frame_on();
    host.quad_byte(CMD_READ_PARAM, 1'b0, r);
    host.quad_byte(8'h23, 1'b0, r);
    host.frame_off();
    chk(32'({dummyCfg, wrapLengthField}), 32'hb);
    // Wrap still enabled here, yet a four-wire read must run straight on
    qread(1'b1, CMD_QUAD_READ, 24'h00003e, 8'h00, 6, 3, 0);
    fourWireMode = 1'b0;
    cmd_frame(CMD_WRAP_SET, 32'h10, 4, 0);
    chk(32'(wrapEnableBit), 32'h1);
    qread(1'b1, CMD_QUAD_READ, 24'h00003e, 8'h00, 4, 3, 0);
  endtask

  task automatic t_prog();
    cmd_frame(CMD_PAGE_PROG, 32'h000300a5, 4, 0);
    chk(32'(writeInProgress), 32'h0);
    cmd_frame(CMD_WRITE_EN, 32'h0, 0, 0);
    chk(32'(writeEnableLatch), 32'h1);
    blockProtect = 5'h01;
    cmd_frame(CMD_PAGE_PROG, 32'hff001011, 4, 0);
    chk(32'(writeInProgress), 32'h0);
    blockProtect = 5'h00;
    cmd_frame(CMD_PAGE_PROG, 32'h00020022, 4, 3);
    chk(32'(writeInProgress), 32'h0);
    cmd_frame(CMD_WRITE_EN, 32'h0, 0, 0);
    words.delete();
    cmd_frame(CMD_PAGE_PROG, 32'h01fea0a1, 4, 0);
    for (int i = 0; i < 3000 && writeInProgress !== 1'b0; i++) @(negedge mclk);
    chk(32'(words.size()), 32'h1);
    chk(32'(words[0]), 32'h01fea0a1);
    cmd_frame(8'ha2, 32'h0, 0, 0);
    chk(32'(writeEnableLatch), 32'h0);
    cmd_frame(CMD_WRITE_EN, 32'h0, 0, 0);
  endtask

  task automatic t_prog_run();
    words.delete();
    host.frame_on();
    host.spi_byte(CMD_PAGE_PROG, r);
    for (int i = 0; i < 3; i++) host.spi_byte(8'(24'h0001fe >> (16 - 8 * i)), r);
    for (int i = 0; i < 3; i++) host.spi_byte(8'ha0 + 8'(i), r);
    host.frame_off();
    chk(32'({writeInProgress, writeEnableLatch}), 32'h2);
    cmd_frame(CMD_STAT_LO, 32'h0, 1, 0);
    host.frame_on();
    host.spi_byte(CMD_STAT_LO, r);
    host.spi_byte(8'h00, r);
    host.frame_off();
    chk(32'(r), 32'h01);
    for (int i = 0; i < 3000 && writeInProgress !== 1'b0; i++) @(negedge mclk);
    chk(32'(words.size()), 32'h3);
    chk(32'(words[0]), 32'h000100a2);
    chk(32'(words[1]), 32'h0001fea0);
    chk(32'(words[2]), 32'h0001ffa1);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge mclk);
    rst <= 1'b0;
    repeat (5) @(negedge mclk);
    t_read();
    t_wrap();
    t_prog();
    t_prog_run();
    close_out();
  end
endmodule
